//--- rtl/cpmv_move_unit.sv
// Purpose: executes the four coprocessor-to-gpr moves
// Assumes: coprocessor register reads answer combinationally
// Notes: one write-back or exception pulse per accepted instruction, one cycle after issue
// Behaviour
// - decode system-control low read: op 010000, bits 25..21 and 10..3 zero
// - ordinary system-control value sign-extended into destination
// - translation-entry low read moves inhibit bits 63,62 to 31,30
// - newest revision: unimplemented system-control read returns zero
// - decode float word read: op 010001, bits 25..21 and 10..0 zero
// - float word read sign-extends bits 31..0 of float register
// - float read: unusable when disabled, reserved when unsupported
// - decode aux word read: op 010010, bits 25..21 zero, pass selector
// - aux coprocessor interprets selector; core sign-extends low word
// - aux read raises unusable exception when that coprocessor disabled
// - decode high system-control read: op 010000, bits 25..21 00011, bits 10..3 zero
// - high read raises reserved exception when high moves disabled
// - extended register high read sign-extends bits 63:32
// - translation-entry high read gives bits 61..30 only with large paddr
// - newest revision: high read of non-extended register returns zero
`timescale 1ns/10ps
`include "cpmv_consts.svh"
module cpmv_move_unit
    import cpmv_pkg::*;
#(
    parameter int GPR_W = 64,
    parameter int AUX_SEL_W = 16
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic issue_valid,
    input wire logic [31:0] instr,
    input wire logic [3:0] arch_rev,
    input wire logic float_enable,
    input wire logic float_supported,
    input wire logic aux_enable,
    input wire logic high_move_enable,
    input wire logic large_paddr_present,
    input wire logic large_paddr_enable,
    output logic [4:0] sysctl_src_index,
    output logic [2:0] sysctl_src_sel,
    input wire logic [63:0] sysctl_rdata,
    input wire logic sysctl_implemented,
    input wire logic sysctl_extended,
    output logic [4:0] src_float_index,
    input wire logic [63:0] float_rdata,
    output logic [AUX_SEL_W-1:0] aux_selector,
    input wire logic [63:0] aux_rdata,
    output logic gpr_we,
    output logic [4:0] dest_gpr_index,
    output logic [GPR_W-1:0] gpr_wdata,
    output logic exc_unusable,
    output logic [1:0] exc_cop_num,
    output logic exc_reserved,
    input wire logic [3:0] sw_addr,
    input wire logic [31:0] sw_wdata,
    input wire logic sw_write,
    input wire logic sw_read,
    output logic [31:0] sw_rdata,
    output logic irq
);
    localparam logic [3:0] ADDR_STATUS = `CPMV_ADDR_STATUS;
    localparam logic [3:0] ADDR_MASK = `CPMV_ADDR_MASK;
    localparam logic [3:0] ADDR_COUNT = `CPMV_ADDR_COUNT;

    function automatic logic [GPR_W-1:0] sext32(input logic [31:0] v);
        sext32 = {{(GPR_W-32){v[31]}}, v};
    endfunction

    logic [5:0] opcode;
    logic [4:0] sub_op;
    cpmv_kind_t kind;
    logic is_xlat;
    logic newest;
    logic [GPR_W-1:0] result;
    logic raise_rsvd;
    logic raise_unusable;
    logic [1:0] cop_num;
    logic [2:0] status_reg;
    logic [2:0] mask_reg;
    logic [15:0] count_reg;
    logic [2:0] event_set;

    assign opcode = instr[31:26];
    assign sub_op = instr[25:21];
    assign sysctl_src_index = instr[15:11];
    assign sysctl_src_sel = instr[2:0];
    assign src_float_index = instr[15:11];
    assign aux_selector = instr[AUX_SEL_W-1:0];
    assign newest = arch_rev >= `CPMV_NEWEST_REV;
    assign is_xlat = (instr[15:11] == `CPMV_XLAT_EVEN_IDX ||
        instr[15:11] == `CPMV_XLAT_ODD_IDX) && instr[2:0] == `CPMV_XLAT_SEL;

    always_comb begin
        kind = CPMV_NONE;
        case (opcode)
            `CPMV_OP_SYSCTL: begin
                if (sub_op == `CPMV_SUB_READ_LOW && instr[10:3] == 8'h00) begin
                    kind = CPMV_SYS_LOW;
                end else if (sub_op == `CPMV_SUB_READ_HIGH && instr[10:3] == 8'h00) begin
                    kind = CPMV_SYS_HIGH;
                end
            end
            `CPMV_OP_FLOAT: begin
                if (sub_op == `CPMV_SUB_READ_LOW && instr[10:0] == 11'h000) begin
                    kind = CPMV_FLOAT;
                end
            end
            `CPMV_OP_AUX: begin
                if (sub_op == `CPMV_SUB_READ_LOW) begin
                    kind = CPMV_AUX;
                end
            end
            default: kind = CPMV_NONE;
        endcase
    end

    always_comb begin
        result = '0;
        raise_rsvd = 1'b0;
        raise_unusable = 1'b0;
        cop_num = 2'h0;
        case (kind)
            CPMV_SYS_LOW: begin
                // pre-newest revisions leave the result open; zero is a safe pick
                if (!sysctl_implemented) begin
                    result = '0;
                end else if (is_xlat) begin
                    result = {{(GPR_W-32){sysctl_rdata[63]}}, sysctl_rdata[63],
                        sysctl_rdata[62], sysctl_rdata[29:0]};
                end else begin
                    result = sext32(sysctl_rdata[31:0]);
                end
            end
            CPMV_SYS_HIGH: begin
                if (!high_move_enable) begin
                    raise_rsvd = 1'b1;
                end else if (!sysctl_implemented || !sysctl_extended) begin
                    result = '0;
                end else if (is_xlat) begin
                    if (large_paddr_present && large_paddr_enable) begin
                        result = sext32(sysctl_rdata[61:30]);
                    end
                end else begin
                    result = sext32(sysctl_rdata[63:32]);
                end
            end
            CPMV_FLOAT: begin
                cop_num = 2'h1;
                if (!float_enable) begin
                    raise_unusable = 1'b1;
                end else if (!float_supported) begin
                    raise_rsvd = 1'b1;
                end else begin
                    result = sext32(float_rdata[31:0]);
                end
            end
            CPMV_AUX: begin
                cop_num = 2'h2;
                if (!aux_enable) begin
                    raise_unusable = 1'b1;
                end else begin
                    result = sext32(aux_rdata[31:0]);
                end
            end
            default: result = '0;
        endcase
    end

    // write-back only; the source register is never written from here
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            gpr_we <= 1'b0;
            dest_gpr_index <= 5'h00;
            gpr_wdata <= '0;
            exc_unusable <= 1'b0;
            exc_reserved <= 1'b0;
            exc_cop_num <= 2'h0;
        end else if (clk_en) begin
            gpr_we <= issue_valid && kind != CPMV_NONE && !raise_rsvd
                && !raise_unusable;
            dest_gpr_index <= instr[20:16];
            gpr_wdata <= result;
            exc_unusable <= issue_valid && raise_unusable;
            exc_reserved <= issue_valid && raise_rsvd;
            exc_cop_num <= cop_num;
        end
    end

    assign event_set = {gpr_we, exc_unusable, exc_reserved};

    // set wins over a same-cycle write-one clear
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            status_reg <= 3'h0;
        end else if (clk_en) begin
            status_reg <= (status_reg & ~((sw_write && sw_addr == ADDR_STATUS) ?
                sw_wdata[2:0] : 3'h0)) | event_set;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mask_reg <= 3'h0;
        end else if (clk_en && sw_write && sw_addr == ADDR_MASK) begin
            mask_reg <= sw_wdata[2:0];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count_reg <= 16'h0000;
        end else if (clk_en && gpr_we) begin
            count_reg <= count_reg + 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sw_rdata <= 32'h0000_0000;
        end else if (clk_en) begin
            sw_rdata <= 32'h0000_0000;
            if (sw_read) begin
                case (sw_addr)
                    ADDR_STATUS: sw_rdata <= {29'h0, status_reg};
                    ADDR_MASK: sw_rdata <= {29'h0, mask_reg};
                    ADDR_COUNT: sw_rdata <= {16'h0000, count_reg};
                    default: sw_rdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign irq = |(status_reg & mask_reg);

    a_high_gate: assert property (@(posedge clk) disable iff (!resetn)
        clk_en && issue_valid && kind == CPMV_SYS_HIGH && !high_move_enable
        |=> exc_reserved && !gpr_we)
        else $error("high read not refused when disabled");
    a_float_unusable: assert property (@(posedge clk) disable iff (!resetn)
        clk_en && issue_valid && kind == CPMV_FLOAT && !float_enable
        |=> exc_unusable && exc_cop_num == 2'h1 && !gpr_we)
        else $error("float read while disabled not flagged");
    a_aux_unusable: assert property (@(posedge clk) disable iff (!resetn)
        clk_en && issue_valid && kind == CPMV_AUX && !aux_enable
        |=> exc_unusable && exc_cop_num == 2'h2)
        else $error("aux read while disabled not flagged");
    a_float_data: assert property (@(posedge clk) disable iff (!resetn)
        clk_en && issue_valid && kind == CPMV_FLOAT && float_enable && float_supported
        |=> gpr_we && gpr_wdata == sext32($past(float_rdata[31:0])))
        else $error("float word read data wrong");
    a_xlat_low: assert property (@(posedge clk) disable iff (!resetn)
        clk_en && issue_valid && kind == CPMV_SYS_LOW && sysctl_implemented && is_xlat
        |=> gpr_wdata[31] == $past(sysctl_rdata[63])
        && gpr_wdata[30] == $past(sysctl_rdata[62]))
        else $error("inhibit bits misplaced");
    a_unimpl_zero: assert property (@(posedge clk) disable iff (!resetn)
        clk_en && issue_valid && kind == CPMV_SYS_LOW && !sysctl_implemented && newest
        |=> gpr_we && gpr_wdata == '0)
        else $error("unimplemented read not zero");
    a_high_ext: assert property (@(posedge clk) disable iff (!resetn)
        clk_en && issue_valid && kind == CPMV_SYS_HIGH && high_move_enable
        && sysctl_implemented && sysctl_extended && !is_xlat
        |=> gpr_wdata == sext32($past(sysctl_rdata[63:32])))
        else $error("high word data wrong");
    a_high_nonext: assert property (@(posedge clk) disable iff (!resetn)
        clk_en && issue_valid && kind == CPMV_SYS_HIGH && high_move_enable
        && !sysctl_extended |=> gpr_we && gpr_wdata == '0)
        else $error("non-extended high read not zero");
    a_xlat_high: assert property (@(posedge clk) disable iff (!resetn)
        clk_en && issue_valid && kind == CPMV_SYS_HIGH && high_move_enable
        && sysctl_implemented && sysctl_extended && is_xlat && !large_paddr_enable
        |=> gpr_wdata == '0)
        else $error("xlat high read without large paddr not zero");
    a_dest_index: assert property (@(posedge clk) disable iff (!resetn)
        clk_en && issue_valid && kind == CPMV_SYS_LOW
        |=> gpr_we && dest_gpr_index == $past(instr[20:16]))
        else $error("destination index wrong");
    a_single_wb: assert property (@(posedge clk) disable iff (!resetn)
        clk_en && !issue_valid |=> !gpr_we)
        else $error("write-back without issue");

    // exception paths: only one outcome per accepted instruction
    a_float_rsvd: assert property (@(posedge clk) disable iff (!resetn)
        clk_en && issue_valid && kind == CPMV_FLOAT && float_enable && !float_supported
        |=> exc_reserved && !exc_unusable && !gpr_we)
        else $error("unsupported float read not refused");
    a_float_prio: assert property (@(posedge clk) disable iff (!resetn)
        clk_en && issue_valid && kind == CPMV_FLOAT && !float_enable
        |=> !exc_reserved)
        else $error("float unusable did not take priority");
    a_aux_no_wb: assert property (@(posedge clk) disable iff (!resetn)
        clk_en && issue_valid && kind == CPMV_AUX && !aux_enable
        |=> !gpr_we && !exc_reserved)
        else $error("aux read written back while disabled");
    a_exc_exclusive: assert property (@(posedge clk) disable iff (!resetn)
        gpr_we |-> !exc_unusable && !exc_reserved)
        else $error("write-back beside an exception");
    a_unrec_quiet: assert property (@(posedge clk) disable iff (!resetn)
        clk_en && issue_valid && kind == CPMV_NONE
        |=> !gpr_we && !exc_unusable && !exc_reserved)
        else $error("unrecognised encoding produced an answer");

    // data paths of the low-word reads
    a_low_sext: assert property (@(posedge clk) disable iff (!resetn)
        clk_en && issue_valid && kind == CPMV_SYS_LOW && sysctl_implemented && !is_xlat
        |=> gpr_wdata == sext32($past(sysctl_rdata[31:0])))
        else $error("ordinary low read not sign-extended");
    a_xlat_low_body: assert property (@(posedge clk) disable iff (!resetn)
        clk_en && issue_valid && kind == CPMV_SYS_LOW && sysctl_implemented && is_xlat
        |=> gpr_wdata[29:0] == $past(sysctl_rdata[29:0]))
        else $error("xlat low body bits wrong");
    a_xlat_low_fill: assert property (@(posedge clk) disable iff (!resetn)
        clk_en && issue_valid && kind == CPMV_SYS_LOW && sysctl_implemented && is_xlat
        |=> gpr_wdata[63:32] == {32{$past(sysctl_rdata[63])}})
        else $error("xlat low upper fill wrong");
    a_float_dest: assert property (@(posedge clk) disable iff (!resetn)
        clk_en && issue_valid && kind == CPMV_FLOAT && float_enable && float_supported
        |=> dest_gpr_index == $past(instr[20:16]))
        else $error("float read destination wrong");
    a_aux_data: assert property (@(posedge clk) disable iff (!resetn)
        clk_en && issue_valid && kind == CPMV_AUX && aux_enable
        |=> gpr_we && gpr_wdata == sext32($past(aux_rdata[31:0])))
        else $error("aux word read data wrong");
    a_aux_dest: assert property (@(posedge clk) disable iff (!resetn)
        clk_en && issue_valid && kind == CPMV_AUX && aux_enable
        |=> dest_gpr_index == $past(instr[20:16]))
        else $error("aux read destination wrong");

    // data paths of the high-word read
    a_high_dest: assert property (@(posedge clk) disable iff (!resetn)
        clk_en && issue_valid && kind == CPMV_SYS_HIGH && high_move_enable
        |=> gpr_we && dest_gpr_index == $past(instr[20:16]))
        else $error("high read destination wrong");
    a_xlat_high_lpa: assert property (@(posedge clk) disable iff (!resetn)
        clk_en && issue_valid && kind == CPMV_SYS_HIGH && high_move_enable
        && sysctl_implemented && sysctl_extended && is_xlat
        && large_paddr_present && large_paddr_enable
        |=> gpr_wdata == sext32($past(sysctl_rdata[61:30])))
        else $error("xlat high read with large paddr wrong");
    a_xlat_high_nolpp: assert property (@(posedge clk) disable iff (!resetn)
        clk_en && issue_valid && kind == CPMV_SYS_HIGH && high_move_enable
        && sysctl_implemented && sysctl_extended && is_xlat && !large_paddr_present
        |=> gpr_wdata == '0)
        else $error("xlat high read without paddr support not zero");
    a_high_unimpl: assert property (@(posedge clk) disable iff (!resetn)
        clk_en && issue_valid && kind == CPMV_SYS_HIGH && high_move_enable
        && !sysctl_implemented |=> gpr_we && gpr_wdata == '0)
        else $error("unimplemented high read not zero");

    // status and enable behaviour
    a_done_sets: assert property (@(posedge clk) disable iff (!resetn)
        clk_en && gpr_we |=> status_reg[`CPMV_ST_BIT_DONE])
        else $error("write-back did not set status");
    a_freeze: assert property (@(posedge clk) disable iff (!resetn)
        !clk_en |=> $stable(gpr_we) && $stable(gpr_wdata) && $stable(status_reg)
        && $stable(count_reg))
        else $error("state moved while clock enable low");
endmodule

//--- rtl/cpmv_consts.svh
// Purpose: constants for the coprocessor move-to-gpr block
// Assumes: 32-bit instruction words, 64-bit general registers
// Notes: opcode and field positions plus register locations
`ifndef CPMV_CONSTS_SVH
`define CPMV_CONSTS_SVH
`define CPMV_OP_SYSCTL 6'h10
`define CPMV_OP_FLOAT 6'h11
`define CPMV_OP_AUX 6'h12
`define CPMV_SUB_READ_LOW 5'h00
`define CPMV_SUB_READ_HIGH 5'h03
`define CPMV_XLAT_EVEN_IDX 5'h02
`define CPMV_XLAT_ODD_IDX 5'h03
`define CPMV_XLAT_SEL 3'h0
`define CPMV_NEWEST_REV 4'h6
`define CPMV_ST_BIT_RSVD 0
`define CPMV_ST_BIT_UNUSABLE 1
`define CPMV_ST_BIT_DONE 2
`define CPMV_ADDR_STATUS 4'h0
`define CPMV_ADDR_MASK 4'h4
`define CPMV_ADDR_COUNT 4'h8
`endif

//--- rtl/cpmv_pkg.sv
// Purpose: types for the coprocessor move-to-gpr block
// Assumes: nothing beyond the constants header
// Notes: instruction classes only
package cpmv_pkg;
    typedef enum logic [2:0] {
        CPMV_NONE,
        CPMV_SYS_LOW,
        CPMV_SYS_HIGH,
        CPMV_FLOAT,
        CPMV_AUX
    } cpmv_kind_t;
endpackage

//--- test/cpmv_cop_model.sv
// Purpose: far-side coprocessor register files answering the move unit
// Assumes: combinational answers in the cycle of the request
// Notes: every aux selector maps to a register, so no unpredictable reads
`timescale 1ns/10ps
module cpmv_cop_model #(
    parameter logic [63:0] V_XLAT = 64'h8000_0000_4123_4567,
    parameter logic [63:0] V_ORD = 64'h9abc_def0_8765_4321,
    parameter logic [63:0] V_FLT = 64'h1111_2222_f654_3210,
    parameter logic [63:0] V_AUX = 64'h5555_6666_f000_0000
) (
    input wire logic [4:0] sysctl_src_index,
    input wire logic [2:0] sysctl_src_sel,
    input wire logic [4:0] src_float_index,
    input wire logic [15:0] aux_selector,
    output logic [63:0] sysctl_rdata,
    output logic sysctl_implemented,
    output logic sysctl_extended,
    output logic [63:0] float_rdata,
    output logic [63:0] aux_rdata
);
    always_comb begin
        sysctl_implemented = (sysctl_src_index != 5'h1f);
        sysctl_extended = (sysctl_src_index inside {5'h02, 5'h03, 5'h04});
        // junk behind an absent register, so a zero result is earned
        if (!sysctl_implemented) begin
            sysctl_rdata = ~V_ORD;
        end else if (sysctl_src_index inside {5'h02, 5'h03} && sysctl_src_sel == 3'h0) begin
            sysctl_rdata = V_XLAT;
        end else begin
            sysctl_rdata = V_ORD;
        end
        float_rdata = V_FLT ^ {59'h0, src_float_index};
        aux_rdata = V_AUX ^ {48'h0, aux_selector};
    end
endmodule

//--- test/coprocessor_move_to_gpr_tb.sv
// Purpose: self-checking bench for the coprocessor move unit
// Assumes: instruction answers just after the taking edge, one cycle after it is driven
// Notes: expectations built from the model's fixed register values
`timescale 1ns/10ps
module coprocessor_move_to_gpr_tb;
    localparam logic [63:0] VX = 64'h8000_0000_4123_4567;
    localparam logic [63:0] VO = 64'h9abc_def0_8765_4321;
    localparam logic [63:0] VF = 64'h1111_2222_f654_3210;
    localparam logic [63:0] VA = 64'h5555_6666_f000_0000;
    logic clk = 0, resetn = 0, issue_valid = 0, sw_write = 0, sw_read = 0;
    logic [31:0] instr = 32'h0000_0000, sw_wdata = 32'h0000_0000, rd;
    logic [3:0] arch_rev = 4'h6, sw_addr = 4'h0;
    logic fen = 1, fsup = 1, aen = 1, hme = 1, lpp = 1, lpe = 1, cen = 1;
    logic [4:0] sidx, fidx, dest;
    logic [2:0] ssel;
    logic [15:0] asel;
    logic [63:0] srd, frd, ard, wdata;
    logic simp, sext, gpr_we, exc_unusable, exc_reserved, irq;
    logic [1:0] exc_cop_num;
    logic [31:0] sw_rdata;
    int fails = 0, tests_run = 0, wb = 0;
    always #4 clk = ~clk;
    cpmv_move_unit i_dut (.clk(clk), .resetn(resetn), .clk_en(cen),
        .issue_valid(issue_valid), .instr(instr), .arch_rev(arch_rev),
        .float_enable(fen), .float_supported(fsup), .aux_enable(aen),
        .high_move_enable(hme), .large_paddr_present(lpp), .large_paddr_enable(lpe),
        .sysctl_src_index(sidx), .sysctl_src_sel(ssel), .sysctl_rdata(srd),
        .sysctl_implemented(simp), .sysctl_extended(sext), .src_float_index(fidx),
        .float_rdata(frd), .aux_selector(asel), .aux_rdata(ard), .gpr_we(gpr_we),
        .dest_gpr_index(dest), .gpr_wdata(wdata), .exc_unusable(exc_unusable),
        .exc_cop_num(exc_cop_num), .exc_reserved(exc_reserved), .sw_addr(sw_addr),
        .sw_wdata(sw_wdata), .sw_write(sw_write), .sw_read(sw_read),
        .sw_rdata(sw_rdata), .irq(irq));
    cpmv_cop_model #(.V_XLAT(VX), .V_ORD(VO), .V_FLT(VF), .V_AUX(VA)) i_model (
        .sysctl_src_index(sidx), .sysctl_src_sel(ssel), .src_float_index(fidx),
        .aux_selector(asel), .sysctl_rdata(srd), .sysctl_implemented(simp),
        .sysctl_extended(sext), .float_rdata(frd), .aux_rdata(ard));
    function automatic logic [63:0] sx(input logic [31:0] w);
        return {{32{w[31]}}, w};
    endfunction
    task automatic end_sim;
        if (fails == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    // ex is {reserved, unusable}
    task automatic run(input logic [31:0] i, input logic we, input logic [63:0] d,
                       input logic [1:0] ex, input logic [1:0] cop);
        @(posedge clk);
        issue_valid <= 1'b1;
        instr <= i;
        @(posedge clk);
        issue_valid <= 1'b0;
        #1;
        chk("gpr_we", we, gpr_we);
        if (we) chk("dest", i[20:16], dest);
        if (we) chk("wdata", d, wdata);
        if (we) wb++;
        chk("exc", ex, {exc_reserved, exc_unusable});
        if (ex[0]) chk("exc_cop_num", cop, exc_cop_num);
        @(posedge clk);
        #1 chk("pulse_end", 3'b000, {gpr_we, exc_reserved, exc_unusable});
    endtask
    task automatic sw_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        sw_write <= 1'b1;
        sw_addr <= a;
        sw_wdata <= d;
        @(posedge clk);
        sw_write <= 1'b0;
    endtask
    task automatic sw_chk(input string n, input logic [3:0] a, input logic [31:0] e);
        @(posedge clk);
        sw_read <= 1'b1;
        sw_addr <= a;
        @(posedge clk);
        sw_read <= 1'b0;
        #1 chk(n, e, sw_rdata);
    endtask
    initial begin
        #200000 fails++;
        end_sim();
    end
    initial begin
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        sw_chk("status_rst", 4'h0, 32'h0000_0000);
        sw_chk("mask_rst", 4'h4, 32'h0000_0000);
        // select field kept zero in every system-control read
        run({6'h10, 5'h00, 5'd7, 5'd4, 11'h0}, 1, sx(VO[31:0]), 0, 0);
        for (int k = 2; k < 4; k++) begin
            run({6'h10, 5'h00, 5'd8, k[4:0], 11'h0}, 1,
                {{32{VX[63]}}, VX[63], VX[62], VX[29:0]}, 0, 0);
        end
        run({6'h10, 5'h00, 5'd6, 5'h1f, 11'h0}, 1, 64'h0, 0, 0);
        // clock enable low: the issue is not taken at all
        cen <= 1'b0;
        run({6'h10, 5'h00, 5'd7, 5'd4, 11'h0}, 0, 64'h0, 0, 0);
        cen <= 1'b1;
        run({6'h11, 5'h00, 5'd9, 5'd3, 11'h0}, 1, sx(VF[31:0] ^ 32'h3), 0, 0);
        run({6'h11, 5'h00, 5'd9, 5'd3, 11'h1}, 0, 64'h0, 0, 0);
        fen <= 1'b0;
        run({6'h11, 5'h00, 5'd9, 5'd3, 11'h0}, 0, 64'h0, 2'b01, 2'd1);
        fen <= 1'b1;
        fsup <= 1'b0;
        run({6'h11, 5'h00, 5'd9, 5'd3, 11'h0}, 0, 64'h0, 2'b10, 2'd0);
        fsup <= 1'b1;
        run({6'h12, 5'h00, 5'd4, 16'h00ab}, 1, sx(VA[31:0] ^ 32'h00ab), 0, 0);
        aen <= 1'b0;
        run({6'h12, 5'h00, 5'd4, 16'h00ab}, 0, 64'h0, 2'b01, 2'd2);
        aen <= 1'b1;
        run({6'h10, 5'h03, 5'd5, 5'd4, 11'h0}, 1, sx(VO[63:32]), 0, 0);
        run({6'h10, 5'h03, 5'd5, 5'd5, 11'h0}, 1, 64'h0, 0, 0);
        run({6'h10, 5'h03, 5'd3, 5'd2, 11'h0}, 1, {{32{VX[61]}}, VX[61:30]}, 0, 0);
        lpe <= 1'b0;
        run({6'h10, 5'h03, 5'd3, 5'd3, 11'h0}, 1, 64'h0, 0, 0);
        hme <= 1'b0;
        run({6'h10, 5'h03, 5'd3, 5'd4, 11'h0}, 0, 64'h0, 2'b10, 2'd0);
        hme <= 1'b1;
        sw_chk("wb_count", 4'h8, wb);
        sw_chk("status", 4'h0, 32'h0000_0007);
        #1 chk("irq_masked", 1'b0, irq);
        sw_wr(4'h4, 32'h0000_0004);
        #1 chk("irq_on", 1'b1, irq);
        sw_chk("mask", 4'h4, 32'h0000_0004);
        sw_wr(4'h0, 32'h0000_0007);
        sw_chk("status_clr", 4'h0, 32'h0000_0000);
        chk("irq_off", 1'b0, irq);
        sw_chk("unmapped", 4'hc, 32'h0000_0000);
        end_sim();
    end
endmodule
